// ### drrsd_pkg.sv
package drrsd_pkg;

  // io ports of the indexed configuration window
  localparam logic [15:0] IO_INDEX_PORT = 16'h0022;
  localparam logic [15:0] IO_DATA_PORT = 16'h0023;

  // configuration indexes
  localparam logic [7:0] IDX_MEM_DECODE = 8'h10;
  localparam logic [7:0] IDX_REMAP_CTRL = 8'h11;
  localparam logic [7:0] IDX_REMAP_ADDR = 8'h12;
  localparam logic [7:0] IDX_SHADOW_LOW = 8'h14;
  localparam logic [7:0] IDX_SHADOW_HIGH = 8'h15;
  localparam logic [7:0] IDX_MC_CTRL = 8'h20;
  localparam logic [7:0] IDX_REFRESH = 8'h36;
  localparam logic [7:0] IDX_AB_SHADOW = 8'h3c;

  // reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;

  // field positions
  localparam int unsigned BIT_ROM_128K = 0;    // memory_decode_control
  localparam int unsigned BIT_CBR = 1;         // memory_decode_control
  localparam int unsigned BIT_HOLE_ISA = 2;    // memory_decode_control
  localparam int unsigned BIT_MOVE_OUT = 1;    // remap_control
  localparam int unsigned BIT_SPLIT_EN = 2;    // remap_control
  localparam int unsigned BIT_AB_REGION = 1;   // remap_address_and_ab_shadow
  localparam int unsigned FLD_REMAP_LSB = 4;   // remap_address_and_ab_shadow
  localparam int unsigned BIT_FLASH_WE = 2;    // memory controller control
  localparam int unsigned BIT_MC_EN = 7;       // memory controller control
  localparam int unsigned FLD_REF_LSB = 4;     // refresh_period_control
  localparam int unsigned BIT_AB_FUNC = 3;     // ab_shadow_function_enable

  // refresh timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REF_ROWS = 256;
  localparam int unsigned REF_WINDOW_MS = 4;
  localparam int unsigned REF_FAST_US = 15;
  localparam int unsigned REF_SLOW_US = 120;
  localparam int unsigned REF_MID_US = 60;
  localparam int unsigned REF_FAST_CYC = REF_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned REF_SLOW_CYC = REF_SLOW_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned REF_MID_CYC = REF_MID_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned REF_CNT_W = 14;

  // dram strobe timing in clocks
  localparam logic [2:0] RAS_CYC = 3'h3;
  localparam logic [2:0] CAS_CYC = 3'h2;
  localparam logic [2:0] PRE_CYC = 3'h2;
  localparam logic [2:0] CBR_LEAD_CYC = 3'h1;

  typedef enum logic [1:0] {TGT_DRAM, TGT_ROM, TGT_ISA} drrsd_target_t;

endpackage

// ### drrsd_top.sv
// Operation
// - default refresh rate is 256 rows per 4 ms, one every 15 us
// - refresh field 00 and 10 give 15 us, 01 gives 120 us, 11 gives 60 us
// - cbr select low gives ras-only refresh
// - cbr select high gives cas-before-ras refresh
// - remap type bit: 0 split, 1 move-out
// - remap megabyte A23-A20 comes from the remap address field
// - split remap needs enable bit set and type bit clear
// - split remap maps A19:17 000,001,010 to 101,110,111, upper zero
// - C0000-FFFFF is eight 32 KB blocks with own read/write enables
// - code 00 off both, 10 read off write dram, 01 read dram protected; off is rom in the bios range, else isa
// - A/B region local only when both enables set, else isa
// - rom size bit: 0 gives 64 KB at F0000, 1 gives 128 KB at E0000
// - flash write strobe only when flash write enable bit is set
// - hole bit: 0 keeps 15M-16M below the rom at FF0000 (FE0000 with 128 KB) local, 1 sends that part to isa
// - controller off sends all to isa and holds dram strobes high
module drrsd_top
  import drrsd_pkg::*;
#(
  parameter int unsigned REF_SLOW_CYCLES = drrsd_pkg::REF_SLOW_CYC,
  parameter int unsigned REF_MID_CYCLES = drrsd_pkg::REF_MID_CYC,
  parameter logic [4:0] DRAM_MB = 5'h10
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_port,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  output logic io_rvalid_q,
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [23:0] cpu_addr,
  output logic cpu_ready_q,
  output logic cpu_done_q,
  output logic isa_cycle_q,
  output logic rom_select_q,
  output logic flash_we_q,
  output logic [6:0] physical_dram_address_upper_q,
  output logic row_strobe_n_q,
  output logic column_strobe_n_q,
  output logic dram_write_strobe_n_q,
  output logic refresh_active_q,
  output logic [7:0] refresh_row_q
);
  import drrsd_pkg::*;

  typedef enum {ST_IDLE, ST_CBR_CAS, ST_REF_RAS, ST_ROW, ST_COL, ST_PRE} drrsd_state_t;

  logic [7:0] index_q;
  logic [7:0] mem_decode_q, remap_ctrl_q, remap_addr_q, shadow_low_q, shadow_high_q;
  logic [7:0] mc_ctrl_q, refresh_ctrl_q, ab_func_q;
  logic [REF_CNT_W-1:0] ref_cnt_q;
  logic ref_tick, ref_pend_q, ref_pend_d;
  drrsd_state_t state_q, state_d;
  logic [2:0] tmr_q;
  logic acc_wr_q, cbr_q, take, start_ref;
  drrsd_target_t tgt;
  logic [6:0] pa;
  logic mc_en, ab_on;

  assign mc_en = mc_ctrl_q[BIT_MC_EN];
  assign ab_on = ab_func_q[BIT_AB_FUNC] & remap_addr_q[BIT_AB_REGION];

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [1:0] blk_code(input logic [2:0] blk);
    logic [15:0] all;
    all = {shadow_high_q, shadow_low_q};
    blk_code = all[{blk, 1'b0} +: 2];
  endfunction

  // a remap target segment is usable only while its lower two 32 KB blocks are unshadowed, or for A/B while ab_on is clear
  function automatic logic seg_free(input logic [2:0] seg);
    seg_free = 1'b0;
    case (seg)
      3'h5: seg_free = !ab_on;
      3'h6: seg_free = (blk_code(3'h0) == 2'h0) && (blk_code(3'h1) == 2'h0);
      3'h7: seg_free = (blk_code(3'h4) == 2'h0) && (blk_code(3'h5) == 2'h0);
      default: seg_free = 1'b0;
    endcase
  endfunction

  function automatic logic in_bios(input logic [23:0] a);
    in_bios = (a[19:16] == 4'hf) || (mem_decode_q[BIT_ROM_128K] && (a[19:16] == 4'he));
  endfunction

  // remapped segment for a cpu address, bit 3 flags a hit
  function automatic logic [3:0] remap_seg(input logic [23:0] a);
    logic [2:0] seg;
    logic hit;
    seg = 3'h0;
    hit = 1'b0;
    if (a[23:20] == remap_addr_q[FLD_REMAP_LSB +: 4] && a[23:20] != 4'h0) begin
      if (remap_ctrl_q[BIT_MOVE_OUT]) begin
        seg = a[19:17];
        hit = a[19] && (a[18:17] != 2'h0);
      end else if (remap_ctrl_q[BIT_SPLIT_EN]) begin
        seg = a[19:17] + 3'h5;
        hit = !a[19] && (a[18:17] != 2'h3);
      end
    end
    remap_seg = {hit && seg_free(seg), seg};
  endfunction

  // target of a cpu memory cycle
  function automatic drrsd_target_t decode(input logic [23:0] a, input logic wr);
    logic [3:0] rs;
    logic [1:0] code;
    rs = remap_seg(a);
    code = blk_code(a[17:15]);
    if (!mc_en) begin
      decode = TGT_ISA;
    end else if (rs[3]) begin
      decode = TGT_DRAM;
    end else if (a[23:16] == 8'hff || (mem_decode_q[BIT_ROM_128K] && a[23:16] == 8'hfe)) begin
      decode = TGT_ROM;
    end else if (a[23:20] == 4'hf && mem_decode_q[BIT_HOLE_ISA]) begin
      decode = TGT_ISA;
    end else if (a[23:20] != 4'h0) begin
      decode = ({1'b0, a[23:20]} < DRAM_MB) ? TGT_DRAM : TGT_ISA;
    end else if (a[19:17] == 3'h5) begin
      decode = ab_on ? TGT_DRAM : TGT_ISA;
    end else if (a[19:18] == 2'h3) begin
      // write uses the upper bit, read the lower
      if (wr ? code[1] : code[0]) begin
        decode = TGT_DRAM;
      end else begin
        decode = in_bios(a) ? TGT_ROM : TGT_ISA;
      end
    end else begin
      decode = TGT_DRAM;
    end
  endfunction

  function automatic logic [6:0] phys_upper(input logic [23:0] a);
    logic [3:0] rs;
    rs = remap_seg(a);
    phys_upper = rs[3] ? {4'h0, rs[2:0]} : a[23:17];
  endfunction

  // a plain assign would only wake on the address and write flag, so a configuration write would leave a stale target
  always_comb begin
    tgt = decode(cpu_addr, cpu_wr);
    pa = phys_upper(cpu_addr);
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration window

  // index latch and configuration writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      index_q <= RST_INDEX;
      mem_decode_q <= RST_CFG;
      remap_ctrl_q <= RST_CFG;
      remap_addr_q <= RST_CFG;
      shadow_low_q <= RST_CFG;
      shadow_high_q <= RST_CFG;
      mc_ctrl_q <= RST_CFG;
      refresh_ctrl_q <= RST_CFG;
      ab_func_q <= RST_CFG;
    end else if (io_wr) begin
      if (io_port == IO_INDEX_PORT) begin
        index_q <= io_wdata;
      end else if (io_port == IO_DATA_PORT) begin
        if (index_q == IDX_MEM_DECODE) mem_decode_q <= io_wdata;
        else if (index_q == IDX_REMAP_CTRL) remap_ctrl_q <= io_wdata;
        else if (index_q == IDX_REMAP_ADDR) remap_addr_q <= io_wdata;
        else if (index_q == IDX_SHADOW_LOW) shadow_low_q <= io_wdata;
        else if (index_q == IDX_SHADOW_HIGH) shadow_high_q <= io_wdata;
        else if (index_q == IDX_MC_CTRL) mc_ctrl_q <= io_wdata;
        else if (index_q == IDX_REFRESH) refresh_ctrl_q <= io_wdata;
        else if (index_q == IDX_AB_SHADOW) ab_func_q <= io_wdata;
      end
    end
  end

  // reads answer one clock later; unknown indexes read as zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_rdata_q <= 8'h00;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_rd && (io_port == IO_INDEX_PORT || io_port == IO_DATA_PORT);
      if (!io_rd) io_rdata_q <= 8'h00;
      else if (io_port == IO_INDEX_PORT) io_rdata_q <= index_q;
      else if (io_port != IO_DATA_PORT) io_rdata_q <= 8'h00;
      else if (index_q == IDX_MEM_DECODE) io_rdata_q <= mem_decode_q;
      else if (index_q == IDX_REMAP_CTRL) io_rdata_q <= remap_ctrl_q;
      else if (index_q == IDX_REMAP_ADDR) io_rdata_q <= remap_addr_q;
      else if (index_q == IDX_SHADOW_LOW) io_rdata_q <= shadow_low_q;
      else if (index_q == IDX_SHADOW_HIGH) io_rdata_q <= shadow_high_q;
      else if (index_q == IDX_MC_CTRL) io_rdata_q <= mc_ctrl_q;
      else if (index_q == IDX_REFRESH) io_rdata_q <= refresh_ctrl_q;
      else if (index_q == IDX_AB_SHADOW) io_rdata_q <= ab_func_q;
      else io_rdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh timer

  function automatic logic [REF_CNT_W-1:0] ref_period(input logic [1:0] sel);
    case (sel)
      2'h1: ref_period = REF_CNT_W'(REF_SLOW_CYCLES - 1);
      2'h3: ref_period = REF_CNT_W'(REF_MID_CYCLES - 1);
      default: ref_period = REF_CNT_W'(REF_FAST_CYC - 1);
    endcase
  endfunction

  assign ref_tick = (ref_cnt_q == '0);

  // free-running interval counter, reloaded at each tick
  always_ff @(posedge clk_sys) begin
    if (srst) ref_cnt_q <= ref_period(2'h0);
    else if (ref_tick) ref_cnt_q <= ref_period(refresh_ctrl_q[FLD_REF_LSB +: 2]);
    else ref_cnt_q <= ref_cnt_q - 1'b1;
  end

  // a tick in the start cycle wins over the clear, so no interval is lost
  assign ref_pend_d = ref_tick | (ref_pend_q & ~start_ref);

  always_ff @(posedge clk_sys) begin
    if (srst) ref_pend_q <= 1'b0;
    else ref_pend_q <= ref_pend_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  assign take = (state_q == ST_IDLE) && cpu_req && cpu_ready_q;
  // refresh only when no cycle is taken
  assign start_ref = (state_q == ST_IDLE) && !take && ref_pend_q && mc_en;

  // next state; a dram strobe state is never entered while disabled
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take && tgt == TGT_DRAM) state_d = ST_ROW;
        else if (start_ref && mem_decode_q[BIT_CBR]) state_d = ST_CBR_CAS;
        else if (start_ref) state_d = ST_REF_RAS;
      end
      ST_CBR_CAS: if (tmr_q == 3'h0) state_d = ST_REF_RAS;
      ST_REF_RAS: if (tmr_q == 3'h0) state_d = ST_PRE;
      ST_ROW: if (tmr_q == 3'h0) state_d = ST_COL;
      ST_COL: if (tmr_q == 3'h0) state_d = ST_PRE;
      ST_PRE: if (tmr_q == 3'h0) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state and phase timer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      tmr_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        case (state_d)
          ST_CBR_CAS: tmr_q <= CBR_LEAD_CYC - 3'h1;
          ST_REF_RAS, ST_ROW: tmr_q <= RAS_CYC - 3'h1;
          ST_COL: tmr_q <= CAS_CYC - 3'h1;
          ST_PRE: tmr_q <= PRE_CYC - 3'h1;
          default: tmr_q <= 3'h0;
        endcase
      end else if (tmr_q != 3'h0) begin
        tmr_q <= tmr_q - 3'h1;
      end
    end
  end

  // cycle context captured when a cycle starts; the refresh row steps when refresh ras ends
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_wr_q <= 1'b0;
      cbr_q <= 1'b0;
      physical_dram_address_upper_q <= 7'h00;
      refresh_row_q <= 8'h00;
    end else begin
      if (take) acc_wr_q <= cpu_wr;
      if (take && tgt == TGT_DRAM) physical_dram_address_upper_q <= pa;
      if (start_ref) cbr_q <= mem_decode_q[BIT_CBR];
      if (state_q == ST_REF_RAS && state_d == ST_PRE) refresh_row_q <= refresh_row_q + 8'h01;
    end
  end

  // strobes and handshakes; ready only drops when refresh or a dram cycle needs the bus
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpu_ready_q <= 1'b0;
      cpu_done_q <= 1'b0;
      isa_cycle_q <= 1'b0;
      rom_select_q <= 1'b0;
      flash_we_q <= 1'b0;
      row_strobe_n_q <= 1'b1;
      column_strobe_n_q <= 1'b1;
      dram_write_strobe_n_q <= 1'b1;
      refresh_active_q <= 1'b0;
    end else begin
      // hold off new cycles while refresh waits
      cpu_ready_q <= (state_d == ST_IDLE) && !(ref_pend_d && mc_en);
      cpu_done_q <= (take && tgt != TGT_DRAM) || (state_q == ST_COL && state_d == ST_PRE);
      isa_cycle_q <= take && tgt == TGT_ISA;
      rom_select_q <= take && tgt == TGT_ROM;
      flash_we_q <= take && tgt == TGT_ROM && cpu_wr && mc_ctrl_q[BIT_FLASH_WE];
      // strobes only move in dram states
      row_strobe_n_q <= !(state_d == ST_ROW || state_d == ST_COL || state_d == ST_REF_RAS);
      column_strobe_n_q <= !(state_d == ST_COL || state_d == ST_CBR_CAS ||
                             (state_d == ST_REF_RAS && state_q != ST_IDLE && cbr_q));
      dram_write_strobe_n_q <= !(state_d == ST_COL && acc_wr_q);
      refresh_active_q <= state_d == ST_CBR_CAS || state_d == ST_REF_RAS ||
                          (state_d == ST_PRE && state_q != ST_COL && refresh_active_q);
    end
  end

endmodule // drrsd_top

// ### drrsd_properties.sv
module drrsd_properties (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_port,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata_q,
  input wire logic io_rvalid_q,
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_ready_q,
  input wire logic cpu_done_q,
  input wire logic isa_cycle_q,
  input wire logic rom_select_q,
  input wire logic flash_we_q,
  input wire logic [6:0] physical_dram_address_upper_q,
  input wire logic row_strobe_n_q,
  input wire logic column_strobe_n_q,
  input wire logic dram_write_strobe_n_q,
  input wire logic refresh_active_q,
  input wire logic [7:0] refresh_row_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // a request counts only at an edge where ready is shown
  sequence take_s;
    cpu_req && cpu_ready_q;
  endsequence
  sequence dram_start_s;
    take_s ##1 (!row_strobe_n_q && !refresh_active_q);
  endsequence
  a_take_resolves: assert property (take_s |=> isa_cycle_q || rom_select_q || !row_strobe_n_q)
    else $error("taken cpu cycle went to no target");
  a_dram_done_six: assert property (dram_start_s |-> ##5 cpu_done_q)
    else $error("dram cycle did not finish at end of cas");
  a_isa_no_strobe: assert property (isa_cycle_q |-> cpu_done_q && row_strobe_n_q && column_strobe_n_q)
    else $error("isa cycle without done or with dram strobes");
  a_flash_rom_write: assert property (flash_we_q |-> rom_select_q && $past(cpu_wr))
    else $error("flash write strobe outside a rom write");
  a_rvalid_follows: assert property (io_rd && (io_port == 16'h0022 || io_port == 16'h0023) |=> io_rvalid_q)
    else $error("config read not answered next cycle");
  a_rvalid_cause: assert property (io_rvalid_q |-> $past(io_rd))
    else $error("read valid without a read");
  // refresh must hold off any new cpu cycle
  a_refresh_blocks: assert property (refresh_active_q |-> !cpu_ready_q)
    else $error("cpu ready during refresh");
  a_row_step_one: assert property ($changed(refresh_row_q) |-> refresh_active_q && refresh_row_q == $past(refresh_row_q) + 8'h01)
    else $error("refresh row counter moved wrongly");
  a_cbr_cas_first: assert property ($fell(column_strobe_n_q) && row_strobe_n_q |-> refresh_active_q ##1 !row_strobe_n_q)
    else $error("cas without ras outside a cbr refresh");
endmodule // drrsd_properties

bind drrsd_top drrsd_properties u_props (.*);

// ### drrsd_dram_isa_model.sv
module drrsd_dram_isa_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic row_strobe_n_q,
  input wire logic column_strobe_n_q,
  input wire logic dram_write_strobe_n_q,
  output logic cbr_seen_q,
  output logic [15:0] refresh_count_q,
  output logic [15:0] fault_count_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ras_prev_q;
  logic cas_prev_q;
  logic cas_in_ras_q;
  // the banks see only strobes, so refresh type is told from their order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ras_prev_q <= 1'b1;
      cas_prev_q <= 1'b1;
      cas_in_ras_q <= 1'b0;
      cbr_seen_q <= 1'b0;
      refresh_count_q <= 16'h0000;
      fault_count_q <= 16'h0000;
    end else begin
      ras_prev_q <= row_strobe_n_q;
      cas_prev_q <= column_strobe_n_q;
      if (!row_strobe_n_q && !column_strobe_n_q) begin
        cas_in_ras_q <= 1'b1;
      end
      if (cas_prev_q && !column_strobe_n_q && row_strobe_n_q) begin
        cbr_seen_q <= 1'b1;
        refresh_count_q <= refresh_count_q + 16'h0001;
      end
      // ras pulse with no cas inside
      if (!ras_prev_q && row_strobe_n_q) begin
        cas_in_ras_q <= 1'b0;
        if (!cas_in_ras_q) begin
          cbr_seen_q <= 1'b0;
          refresh_count_q <= refresh_count_q + 16'h0001;
        end
      end
      // a write strobe with no open row would corrupt a bank
      if (!dram_write_strobe_n_q && row_strobe_n_q) begin
        fault_count_q <= fault_count_q + 16'h0001;
      end
    end
  end
endmodule // drrsd_dram_isa_model

// ### dram_refresh_remap_shadow_decode_bench.sv
module dram_refresh_remap_shadow_decode_bench;
  import drrsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [55:0] cfg;
    logic wr;
    logic [23:0] a;
    drrsd_target_t k;
    logic [6:0] pa;
    logic fl;
  } drrsd_case_t;
  logic clk_sys = 1'b0, srst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, cpu_req = 1'b0, cpu_wr = 1'b0;
  logic [15:0] io_port = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic [23:0] cpu_addr = 24'h000000;
  logic [7:0] io_rdata_q, refresh_row_q;
  logic io_rvalid_q, cpu_ready_q, cpu_done_q, isa_cycle_q, rom_select_q, flash_we_q, refresh_active_q;
  logic row_strobe_n_q, column_strobe_n_q, dram_write_strobe_n_q, cbr_seen_q;
  logic [6:0] physical_dram_address_upper_q;
  logic [15:0] refresh_count_q, fault_count_q;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] idx [7] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h20, 8'h3c};
  int per [4] = '{1500, 40, 1500, 30};
  drrsd_case_t rows [24];
  drrsd_top #(.REF_SLOW_CYCLES(40), .REF_MID_CYCLES(30)) dut (.*);
  drrsd_dram_isa_model far_side (.*);
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // index byte then data byte, then one idle edge so a following call
  // never raises the write strobe in the step that lowered it
  task automatic wcfg(input logic [7:0] ix, input logic [7:0] d);
    io_wr = 1'b1;
    io_port = 16'h0022;
    io_wdata = ix;
    @(posedge clk_sys);
    #1;
    io_port = 16'h0023;
    io_wdata = d;
    @(posedge clk_sys);
    #1;
    io_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // read data stands for one cycle only, so it is taken right after the answering edge
  task automatic rcfg(input logic [7:0] ix, input logic [7:0] exp);
    io_wr = 1'b1;
    io_port = 16'h0022;
    io_wdata = ix;
    @(posedge clk_sys);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b1;
    io_port = 16'h0023;
    @(posedge clk_sys);
    #1;
    io_rd = 1'b0;
    chk_val({io_rvalid_q, io_rdata_q}, {1'b1, exp});
  endtask
  // wait for ready, hold the request over the taking edge, then watch
  task automatic mem(input logic wr, input logic [23:0] a, output drrsd_target_t k, output logic [6:0] pa,
                     output logic fl);
    int n;
    logic done;
    logic ws;
    n = 0;
    done = 1'b0;
    ws = 1'b0;
    k = TGT_DRAM;
    pa = 7'h7f;
    fl = 1'b0;
    while (cpu_ready_q !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cpu_req = 1'b1;
    cpu_wr = wr;
    cpu_addr = a;
    @(posedge clk_sys);
    #1;
    cpu_req = 1'b0;
    for (n = 0; n < 12 && !done; n++) begin
      if (isa_cycle_q === 1'b1) k = TGT_ISA;
      if (rom_select_q === 1'b1) begin
        k = TGT_ROM;
        fl = flash_we_q;
      end
      if (row_strobe_n_q === 1'b0 && refresh_active_q === 1'b0) pa = physical_dram_address_upper_q;
      if (dram_write_strobe_n_q === 1'b0) ws = 1'b1;
      done = (cpu_done_q === 1'b1);
      if (!done) begin
        @(posedge clk_sys);
        #1;
      end
    end
    chk_val(done, 1'b1);
    // a dram write must pulse the write strobe, a dram read must leave it high
    if (k == TGT_DRAM) chk_val(ws, wr);
  endtask
  // refresh spacing as seen by the banks
  task automatic gap(output int g);
    logic [15:0] c;
    g = 0;
    c = refresh_count_q;
    while (refresh_count_q === c && g < 20000) begin
      @(posedge clk_sys);
      #1;
      g++;
    end
    g = 0;
    c = refresh_count_q;
    while (refresh_count_q === c && g < 20000) begin
      @(posedge clk_sys);
      #1;
      g++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #500us;
    failures++;
    tally_and_finish();
  end
  initial begin
    drrsd_target_t k;
    logic [6:0] pa;
    logic fl;
    int g;
    logic [7:0] r;
    // cfg order 10h 11h 12h 14h 15h 20h 3ch
    // split with enable set, move-out only at field 1111
    rows = '{'{56'h00000000000000, 0, 24'h100000, TGT_ISA, 0, 0}, '{56'h00000000008000, 0, 24'h100000, TGT_DRAM, 8, 0},
      '{56'h0004d000008000, 0, 24'hd00000, TGT_DRAM, 5, 0}, '{56'h0004d000008000, 0, 24'hd20000, TGT_DRAM, 6, 0},
      '{56'h0004d000008000, 0, 24'hd40000, TGT_DRAM, 7, 0}, '{56'h0000d000008000, 0, 24'hd00000, TGT_DRAM, 7'h68, 0},
      '{56'h0002f000008000, 0, 24'hfa0000, TGT_DRAM, 5, 0}, '{56'h0002f000008000, 1, 24'hfc0000, TGT_DRAM, 6, 0},
      '{56'h04000000008000, 0, 24'hf00000, TGT_ISA, 0, 0}, '{56'h00000000008000, 0, 24'hf00000, TGT_DRAM, 7'h78, 0},
      '{56'h00000200008008, 0, 24'h0a0000, TGT_DRAM, 5, 0}, '{56'h00000000008008, 0, 24'h0a0000, TGT_ISA, 0, 0},
      '{56'h00000000008000, 0, 24'h0f0000, TGT_ROM, 0, 0}, '{56'h00000000008000, 0, 24'h0e0000, TGT_ISA, 0, 0},
      '{56'h01000000008000, 0, 24'h0e0000, TGT_ROM, 0, 0}, '{56'h00000002008000, 1, 24'h0c0000, TGT_DRAM, 6, 0},
      '{56'h00000002008000, 0, 24'h0c0000, TGT_ISA, 0, 0}, '{56'h00000001008000, 0, 24'h0c0000, TGT_DRAM, 6, 0},
      '{56'h00000001008000, 1, 24'h0c0000, TGT_ISA, 0, 0}, '{56'h00000000408000, 0, 24'h0f8000, TGT_DRAM, 7, 0},
      '{56'h00000000008400, 1, 24'h0f0000, TGT_ROM, 0, 1}, '{56'h00000000008000, 1, 24'h0f0000, TGT_ROM, 0, 0},
      '{56'h01000000008000, 0, 24'hfe0000, TGT_ROM, 0, 0}, '{56'h00000000008000, 0, 24'hff0000, TGT_ROM, 0, 0}};
    repeat (20) @(posedge clk_sys);
    #1;
    chk_val({cpu_ready_q, row_strobe_n_q, column_strobe_n_q}, 3'h3);
    srst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk_val(cpu_ready_q, 1'b1);
    // configuration starts cleared, unknown index reads zero
    for (int j = 0; j < 7; j++) rcfg(idx[j], 8'h00);
    wcfg(8'h13, 8'ha5);
    rcfg(8'h13, 8'h00);
    // one access per row under its own configuration
    for (int i = 0; i < 24; i++) begin
      for (int j = 0; j < 7; j++) wcfg(idx[j], rows[i].cfg[55 - 8 * j -: 8]);
      mem(rows[i].wr, rows[i].a, k, pa, fl);
      chk_val(k, rows[i].k);
      if (rows[i].k == TGT_DRAM) chk_val(pa, rows[i].pa);
      chk_val(fl, rows[i].fl);
    end
    rcfg(8'h20, 8'h80);
    // every refresh code, alternating ras-only and cbr
    for (int i = 0; i < 4; i++) begin
      wcfg(8'h10, {6'h00, i[0], 1'b0});
      wcfg(8'h36, {2'h0, i[1:0], 4'h0});
      gap(g);
      r = refresh_row_q;
      gap(g);
      chk_val(g, per[i]);
      chk_val(cbr_seen_q, i[0]);
      // the second spacing spans two refreshes, so the row counter moves by two
      chk_val(refresh_row_q, 8'(r + 8'h02));
    end
    // a dram cycle asked for right around a refresh still completes
    mem(1'b0, 24'h200000, k, pa, fl);
    chk_val(pa, 7'h10);
    chk_val(fault_count_q, 16'h0000);
    // reset in mid-run clears configuration again
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    @(posedge clk_sys);
    #1;
    rcfg(8'h20, 8'h00);
    // with the controller off the timer still runs, yet no refresh may reach the banks
    repeat (1600) @(posedge clk_sys);
    #1;
    chk_val({cpu_ready_q, refresh_count_q}, {1'b1, 16'h0000});
    tally_and_finish();
  end
endmodule // dram_refresh_remap_shadow_decode_bench
